// ===== core/ssd_pkg.sv
// constants and types shared by the serial status, data and checksum block
package ssd_pkg;
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;
	localparam int REG_W = 16;
	localparam int FIFO_DEPTH = 8;

	// register byte offsets
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_DATA = 8'h0c;
	localparam logic [7:0] OFF_POLY = 8'h10;
	localparam logic [7:0] OFF_RX_CHECKSUM_ACCUMULATOR = 8'h14;
	localparam logic [7:0] OFF_TX_CHECKSUM_ACCUMULATOR = 8'h18;
	localparam logic [7:0] OFF_CTRL = 8'h24;

	// reset values
	localparam logic [15:0] RST_STATUS = 16'h0002;
	localparam logic [15:0] RST_DATA = 16'h0000;
	localparam logic [15:0] RST_POLY = 16'h0007;
	localparam logic [15:0] RST_CRC = 16'h0000;

	// status bit positions
	localparam int ST_RXNE = 0;
	localparam int ST_TXE = 1;
	localparam int ST_SIDE = 2;
	localparam int ST_UDR = 3;
	localparam int ST_CRCE = 4;
	localparam int ST_MODF = 5;
	localparam int ST_OVR = 6;
	localparam int ST_BUSY = 7;

	// frame geometry
	localparam int W8_MSB = 7;
	localparam int W16_MSB = 15;
	localparam logic [4:0] LAST_BIT8 = 5'h07;
	localparam logic [4:0] LAST_BIT16 = 5'h0f;
	localparam logic [4:0] BIT_ZERO = 5'h00;
	localparam logic [4:0] BIT_ONE = 5'h01;

	// synchronised pin indices
	localparam int PIN_SCK = 0;
	localparam int PIN_MOSI = 1;
	localparam int PIN_NSS = 2;
	localparam int PIN_WS = 3;
	localparam int PIN_N = 4;

	// control register, bit 0 at the bottom
	typedef struct packed {
		logic pcm_mode;
		logic audio_mode;
		logic rx_dma_request_enable;
		logic send_checksum_next;
		logic checksum_enable;
		logic frame_width_select;
		logic enable;
	} ssd_ctrl_t;
	localparam int CTRL_W = 7;
	localparam logic [6:0] RST_CTRL = 7'h00;

	typedef struct packed {
		logic rx_not_empty_flag;
		logic underrun_flag;
		logic checksum_mismatch_flag;
		logic mode_fault_flag;
		logic overrun_flag;
	} ssd_flags_t;

	typedef enum logic [0:0] {
		SH_IDLE = 1'b0,
		SH_SHIFT = 1'b1
	} ssd_state_t;
endpackage

// ===== core/ssd_top.sv
// serial status, data port and checksum block with its transmit fifo
//
// Operation
// - status bit 0: receive buffer not empty
// - status bit 1: transmit empty, resets 0x0002
// - status bit 2: audio channel side
// - status bit 3: audio underrun, write 0 clears
// - status bit 4: spi checksum mismatch, write 0
// - status bit 5: spi mode fault, write 0
// - status bit 6: receive overrun, write 0 clears
// - status bit 7: busy while transferring
// - data write loads tx, read returns rx
// - 8-bit frames use only low byte
// - polynomial register, resets to 0x0007
// - receive checksum, crc8 or crc16 by width
// - transmit checksum, crc8 or crc16 by width
// - checksum enable set clears both accumulators
// - rx dma request when not-empty flag set
// - send-checksum-next sends accumulator as next frame
// - width select: 0 8-bit, changes only disabled
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns

module ssd_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready_o = count != FULL;
	assign out_valid_o = count != '0;
	assign out_data_o = mem[rd_ptr];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end

	// storage has no reset; empty entries are never presented as valid
	always_ff @(posedge clk_i) begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end
endmodule

module ssd_top (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic nss_n_i,
	input wire logic ws_i,
	input wire logic mode_fault_i,
	output logic miso_o,
	output logic miso_oe_o,
	output logic rx_dma_req_o
);
	ssd_pkg::ssd_ctrl_t ctrl;
	ssd_pkg::ssd_flags_t flags;
	ssd_pkg::ssd_state_t state;
	logic [15:0] poly;
	logic [15:0] rx_data;
	logic [15:0] rx_crc;
	logic [15:0] tx_crc;
	logic [15:0] rx_crc_snap;
	logic [15:0] tx_sh;
	logic [15:0] rx_sh;
	logic [4:0] bit_cnt;
	logic crc_phase;
	logic [15:0] status;
	logic [15:0] next_read;
	logic access;
	logic wr_fire;
	logic rd_fire;
	logic data_wr_req;
	logic mapped;
	logic fifo_in_ready;
	logic fifo_valid;
	logic [15:0] fifo_data;
	logic fifo_pop;
	logic [ssd_pkg::PIN_N-1:0] pin_raw;
	logic [ssd_pkg::PIN_N-1:0] sync1;
	logic [ssd_pkg::PIN_N-1:0] sync2;
	logic [ssd_pkg::PIN_N-1:0] sync3;
	logic [ssd_pkg::PIN_N-1:0] settled;
	logic [ssd_pkg::PIN_N-1:0] settled_d;
	logic sck_rise;
	logic sck_fall;
	logic nss_act;
	logic load;
	logic sample;
	logic last_bit;
	logic frame_end;
	logic in_bit;
	logic out_bit;
	logic [15:0] rx_word;
	logic store_ok;
	logic overrun_ev;
	logic underrun_ev;
	logic crc_err_ev;
	logic modf_ev;
	logic crc_clear;
	logic flag_clr_wr;
	logic wide;

	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [15:0] p,
		input logic b, input logic w16);
		logic fb;
		logic [15:0] nx;
		fb = b ^ (w16 ? crc[ssd_pkg::W16_MSB] : crc[ssd_pkg::W8_MSB]);
		nx = {crc[14:0], 1'b0} ^ (fb ? p : 16'h0000);
		crc_step = w16 ? nx : {8'h00, nx[7:0]};
	endfunction

	// apb slave: reads are captured in the setup cycle, so no wait states except a full fifo
	assign access = psel_i & penable_i;
	assign data_wr_req = access & pwrite_i & (paddr_i == ssd_pkg::OFF_DATA);
	assign pready_o = !(data_wr_req && !fifo_in_ready);
	assign mapped = paddr_i == ssd_pkg::OFF_STATUS || paddr_i == ssd_pkg::OFF_DATA ||
		paddr_i == ssd_pkg::OFF_POLY || paddr_i == ssd_pkg::OFF_RX_CHECKSUM_ACCUMULATOR ||
		paddr_i == ssd_pkg::OFF_TX_CHECKSUM_ACCUMULATOR || paddr_i == ssd_pkg::OFF_CTRL;
	assign pslverr_o = access & !mapped;
	assign wr_fire = access & pwrite_i & pready_o;
	assign rd_fire = access & !pwrite_i;
	assign wide = ctrl.frame_width_select;

	always_comb begin
		status = 16'h0000;
		status[ssd_pkg::ST_RXNE] = flags.rx_not_empty_flag;
		status[ssd_pkg::ST_TXE] = !fifo_valid;
		status[ssd_pkg::ST_SIDE] = ctrl.audio_mode & !ctrl.pcm_mode & settled[ssd_pkg::PIN_WS];
		status[ssd_pkg::ST_UDR] = flags.underrun_flag;
		status[ssd_pkg::ST_CRCE] = flags.checksum_mismatch_flag;
		status[ssd_pkg::ST_MODF] = flags.mode_fault_flag;
		status[ssd_pkg::ST_OVR] = flags.overrun_flag;
		status[ssd_pkg::ST_BUSY] = state == ssd_pkg::SH_SHIFT;
	end

	always_comb begin
		unique case (paddr_i)
			ssd_pkg::OFF_STATUS: next_read = status;
			ssd_pkg::OFF_DATA: next_read = rx_data;
			ssd_pkg::OFF_POLY: next_read = poly;
			ssd_pkg::OFF_RX_CHECKSUM_ACCUMULATOR: next_read = rx_crc;
			ssd_pkg::OFF_TX_CHECKSUM_ACCUMULATOR: next_read = tx_crc;
			ssd_pkg::OFF_CTRL: next_read = {9'h000, ctrl};
			default: next_read = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			prdata_o <= 32'h00000000;
		else if (psel_i && !penable_i && !pwrite_i)
			prdata_o <= {16'h0000, next_read};
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			poly <= ssd_pkg::RST_POLY;
		end else if (wr_fire && paddr_i == ssd_pkg::OFF_POLY) begin
			poly <= pwdata_i[15:0];
		end
	end

	// width and checksum enable are frozen while the engine is enabled
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl <= ssd_pkg::RST_CTRL;
		end else if (wr_fire && paddr_i == ssd_pkg::OFF_CTRL) begin
			ctrl.enable <= pwdata_i[0];
			ctrl.send_checksum_next <= pwdata_i[3];
			ctrl.rx_dma_request_enable <= pwdata_i[4];
			ctrl.audio_mode <= pwdata_i[5];
			ctrl.pcm_mode <= pwdata_i[6];
			if (!ctrl.enable) begin
				ctrl.frame_width_select <= pwdata_i[1];
				ctrl.checksum_enable <= pwdata_i[2];
			end
		end else if (load && ctrl.send_checksum_next) begin
			ctrl.send_checksum_next <= 1'b0;
		end
	end

	assign crc_clear = wr_fire && paddr_i == ssd_pkg::OFF_CTRL && !ctrl.enable &&
		pwdata_i[2] && !ctrl.checksum_enable;

	ssd_fifo #(
		.WIDTH(ssd_pkg::REG_W),
		.DEPTH(ssd_pkg::FIFO_DEPTH)
	) tx_fifo (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.in_data_i(pwdata_i[15:0]),
		.in_valid_i(data_wr_req),
		.in_ready_o(fifo_in_ready),
		.out_data_o(fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop)
	);

	// pins: three flops, a level counts once the second and third agree
	assign pin_raw = {ws_i, !nss_n_i, mosi_i, sck_i};
	genvar gi;
	generate
		for (gi = 0; gi < ssd_pkg::PIN_N; gi++) begin : g_sync
			always_ff @(posedge clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
					sync3[gi] <= 1'b0;
					settled[gi] <= 1'b0;
					settled_d[gi] <= 1'b0;
				end else begin
					sync1[gi] <= pin_raw[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					if (sync2[gi] == sync3[gi])
						settled[gi] <= sync3[gi];
					settled_d[gi] <= settled[gi];
				end
			end
		end
	endgenerate

	assign sck_rise = settled[ssd_pkg::PIN_SCK] & !settled_d[ssd_pkg::PIN_SCK];
	assign sck_fall = !settled[ssd_pkg::PIN_SCK] & settled_d[ssd_pkg::PIN_SCK];
	assign nss_act = settled[ssd_pkg::PIN_NSS];
	assign in_bit = settled[ssd_pkg::PIN_MOSI];
	assign load = state == ssd_pkg::SH_IDLE && nss_act && ctrl.enable;
	assign fifo_pop = load && !ctrl.send_checksum_next && fifo_valid;
	assign sample = state == ssd_pkg::SH_SHIFT && nss_act && sck_rise;
	assign last_bit = bit_cnt == (wide ? ssd_pkg::LAST_BIT16 : ssd_pkg::LAST_BIT8);
	assign frame_end = sample && last_bit;
	assign out_bit = wide ? tx_sh[ssd_pkg::W16_MSB] : tx_sh[ssd_pkg::W8_MSB];
	assign rx_word = wide ? {rx_sh[14:0], in_bit} : {8'h00, rx_sh[6:0], in_bit};
	assign store_ok = frame_end && !flags.rx_not_empty_flag;
	assign overrun_ev = frame_end && flags.rx_not_empty_flag;
	assign underrun_ev = load && ctrl.audio_mode && !ctrl.send_checksum_next && !fifo_valid;
	assign crc_err_ev = frame_end && crc_phase && !ctrl.audio_mode && rx_word != rx_crc_snap;
	assign modf_ev = mode_fault_i && !ctrl.audio_mode;
	assign flag_clr_wr = wr_fire && paddr_i == ssd_pkg::OFF_STATUS;

	assign miso_o = out_bit;
	assign miso_oe_o = state == ssd_pkg::SH_SHIFT && nss_act;
	assign rx_dma_req_o = ctrl.rx_dma_request_enable & flags.rx_not_empty_flag;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= ssd_pkg::SH_IDLE;
			bit_cnt <= ssd_pkg::BIT_ZERO;
			crc_phase <= 1'b0;
			tx_sh <= ssd_pkg::RST_DATA;
			rx_sh <= ssd_pkg::RST_DATA;
			rx_crc_snap <= ssd_pkg::RST_CRC;
		end else begin
			unique case (state)
				ssd_pkg::SH_IDLE: begin
					if (load) begin
						state <= ssd_pkg::SH_SHIFT;
						bit_cnt <= ssd_pkg::BIT_ZERO;
						crc_phase <= ctrl.send_checksum_next;
						rx_crc_snap <= rx_crc;
						if (ctrl.send_checksum_next)
							tx_sh <= tx_crc;
						else if (fifo_valid)
							tx_sh <= wide ? fifo_data : {8'h00, fifo_data[7:0]};
						else
							tx_sh <= ssd_pkg::RST_DATA;
					end
				end
				ssd_pkg::SH_SHIFT: begin
					if (!nss_act || frame_end) begin
						state <= ssd_pkg::SH_IDLE;
					end else if (sample) begin
						rx_sh <= {rx_sh[14:0], in_bit};
						bit_cnt <= bit_cnt + ssd_pkg::BIT_ONE;
					end else if (sck_fall && bit_cnt != ssd_pkg::BIT_ZERO) begin
						// no shift on the trailing edge after a reload: the new msb is already out
						tx_sh <= {tx_sh[14:0], 1'b0};
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_crc <= ssd_pkg::RST_CRC;
			tx_crc <= ssd_pkg::RST_CRC;
		end else if (crc_clear) begin
			rx_crc <= ssd_pkg::RST_CRC;
			tx_crc <= ssd_pkg::RST_CRC;
		end else if (sample && ctrl.checksum_enable) begin
			rx_crc <= crc_step(rx_crc, poly, in_bit, wide);
			if (!crc_phase)
				tx_crc <= crc_step(tx_crc, poly, out_bit, wide);
		end
	end

	// receive buffer: an overrun keeps the older word
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			rx_data <= ssd_pkg::RST_DATA;
		else if (store_ok)
			rx_data <= rx_word;
	end

	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flags <= '0;
		end else begin
			if (store_ok)
				flags.rx_not_empty_flag <= 1'b1;
			else if (rd_fire && paddr_i == ssd_pkg::OFF_DATA)
				flags.rx_not_empty_flag <= 1'b0;
			if (underrun_ev)
				flags.underrun_flag <= 1'b1;
			else if (flag_clr_wr && !pwdata_i[ssd_pkg::ST_UDR])
				flags.underrun_flag <= 1'b0;
			if (crc_err_ev)
				flags.checksum_mismatch_flag <= 1'b1;
			else if (flag_clr_wr && !pwdata_i[ssd_pkg::ST_CRCE])
				flags.checksum_mismatch_flag <= 1'b0;
			if (modf_ev)
				flags.mode_fault_flag <= 1'b1;
			else if (flag_clr_wr && !pwdata_i[ssd_pkg::ST_MODF])
				flags.mode_fault_flag <= 1'b0;
			if (overrun_ev)
				flags.overrun_flag <= 1'b1;
			else if (flag_clr_wr && !pwdata_i[ssd_pkg::ST_OVR])
				flags.overrun_flag <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	rxne_set_a: assert property (store_ok |=> flags.rx_not_empty_flag && rx_data == $past(rx_word))
		else $error("word stored without not-empty flag");
	rxne_read_clear_a: assert property (rd_fire && paddr_i == ssd_pkg::OFF_DATA && !store_ok
		|=> !flags.rx_not_empty_flag)
		else $error("data read did not clear not-empty flag");
	txe_write_a: assert property (data_wr_req && fifo_in_ready |=> !status[ssd_pkg::ST_TXE])
		else $error("transmit empty still shown after write");
	udr_set_a: assert property (underrun_ev |=> flags.underrun_flag)
		else $error("underrun not flagged");
	crc_err_a: assert property (crc_err_ev |=> flags.checksum_mismatch_flag)
		else $error("checksum mismatch not flagged");
	mode_fault_a: assert property (modf_ev |=> flags.mode_fault_flag)
		else $error("mode fault not flagged");
	ovr_keep_a: assert property (overrun_ev |=> flags.overrun_flag && $stable(rx_data))
		else $error("overrun not flagged or data replaced");
	busy_load_a: assert property (load |=> status[ssd_pkg::ST_BUSY] && miso_oe_o == nss_act)
		else $error("busy not raised on frame load");
	crc_clear_a: assert property (crc_clear |=> rx_crc == ssd_pkg::RST_CRC && tx_crc == ssd_pkg::RST_CRC)
		else $error("checksums not cleared on enable");
	dma_req_a: assert property ($rose(flags.rx_not_empty_flag) && ctrl.rx_dma_request_enable |-> rx_dma_req_o)
		else $error("dma request missing");
	crc_next_a: assert property (load && ctrl.send_checksum_next
		|=> tx_sh == $past(tx_crc) && crc_phase && !ctrl.send_checksum_next)
		else $error("checksum not sent as next frame");
	width8_a: assert property (store_ok && !wide |=> rx_data[15:8] == 8'h00)
		else $error("upper byte used in 8-bit frame");
	width_lock_a: assert property (ctrl.enable |=> $stable(ctrl.frame_width_select))
		else $error("frame width changed while enabled");
endmodule

// ===== testbench/ssd_link_model.sv
// external spi master model: mode 0, msb first, sck period 160 ns
`timescale 1ns/1ns
module ssd_link_model (
	output logic sck_o,
	output logic mosi_o,
	output logic nss_n_o,
	input wire logic miso_i
);
	initial begin
		sck_o = 1'b0;
		mosi_o = 1'b0;
		nss_n_o = 1'b1;
	end
	// odd offset keeps pin edges away from the block clock edges
	task automatic select();
		nss_n_o = 1'b0;
		#205;
	endtask
	// mosi moves halfway through the low phase: the block sees each rise only after its synchroniser
	task automatic frame(input logic w16, input logic [15:0] tx, output logic [15:0] rx);
		int n;
		n = w16 ? 16 : 8;
		rx = 16'h0000;
		for (int i = n - 1; i >= 0; i--) begin
			#40;
			mosi_o = tx[i];
			#40;
			sck_o = 1'b1;
			#80;
			rx = {rx[14:0], miso_i};
			sck_o = 1'b0;
		end
	endtask
	task automatic deselect();
		#160;
		nss_n_o = 1'b1;
		// a released line must not keep showing the last bit
		mosi_o = ~mosi_o;
		#200;
	endtask
endmodule

// ===== testbench/tb.sv
// self-checking bench for the serial status, data and checksum block
`timescale 1ns/1ns
module tb;
	logic clk_i = 1'h0;
	logic nrst_i = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic mfault = 1'h0;
	logic ws = 1'h0;
	logic w16 = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, rerr, sck, mosi, nss_n, miso, miso_oe, dreq;
	logic [15:0] rxc, txc, poly, d, q, r;
	logic [15:0] fq[$];
	int error_cnt = 0;
	int n_checks = 0;
	always #10 clk_i = ~clk_i;
	ssd_top u_ssd_top (.clk_i(clk_i), .nrst_i(nrst_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.sck_i(sck), .mosi_i(mosi), .nss_n_i(nss_n), .ws_i(ws), .mode_fault_i(mfault), .miso_o(miso),
		.miso_oe_o(miso_oe), .rx_dma_req_o(dreq));
	ssd_link_model u_lnk (.sck_o(sck), .mosi_o(mosi), .nss_n_o(nss_n), .miso_i(miso));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// the access phase lasts until pready is sampled high; only the watchdog ends the wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk_i);
		penable <= 1'h1;
		do @(posedge clk_i); while (pready !== 1'h1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'h1, a, v);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'h0, a, 32'h0);
	endtask
	task automatic st(input int b, input logic v);
		rd(ssd_pkg::OFF_STATUS);
		chk(rdat[b], v);
	endtask
	function automatic logic [15:0] m(input logic [15:0] x);
		return w16 ? x : {8'h00, x[7:0]};
	endfunction
	function automatic logic [15:0] crc(input logic [15:0] c, input logic [15:0] x);
		int n;
		n = w16 ? 16 : 8;
		for (int i = n - 1; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[n-1] ^ x[i]) ? m(poly) : 16'h0000);
		return m(c);
	endfunction
	task automatic xf(input logic [15:0] mo, input logic [15:0] mi);
		u_lnk.frame(w16, mo, r);
		chk(r, m(mi));
	endtask
	// enabling the checksum while disabled clears both accumulators
	// the first write disables, the second can then drop the frozen checksum enable, so the next one is a 0->1 set
	task automatic cfg(input logic [15:0] c);
		wr(ssd_pkg::OFF_CTRL, 32'h0);
		wr(ssd_pkg::OFF_CTRL, 32'h0);
		wr(ssd_pkg::OFF_CTRL, {16'h0, c & 16'hfffe});
		wr(ssd_pkg::OFF_CTRL, {16'h0, c});
		rxc = 16'h0000;
		txc = 16'h0000;
	endtask
	initial begin
		#400000;
		error_cnt++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_sim();
	end
	initial begin
		void'($urandom(65332));
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'h1;
		repeat (5) @(posedge clk_i);
		rd(ssd_pkg::OFF_STATUS);
		chk(rdat, 32'h2);
		rd(ssd_pkg::OFF_DATA);
		chk(rdat, 32'h0);
		rd(ssd_pkg::OFF_POLY);
		chk(rdat, 32'h7);
		wr(ssd_pkg::OFF_RX_CHECKSUM_ACCUMULATOR, 32'hffff);
		rd(ssd_pkg::OFF_RX_CHECKSUM_ACCUMULATOR);
		chk(rdat, 32'h0);
		wr(ssd_pkg::OFF_TX_CHECKSUM_ACCUMULATOR, 32'hffff);
		rd(ssd_pkg::OFF_TX_CHECKSUM_ACCUMULATOR);
		chk(rdat, 32'h0);
		rd(8'h40);
		chk({rerr, rdat[30:0]}, 32'h80000000);
		poly = $urandom;
		wr(ssd_pkg::OFF_POLY, {16'h0, poly});
		rd(ssd_pkg::OFF_POLY);
		chk(rdat, {16'h0, poly});
		$display("test registers done");
		for (int k = 0; k < 2; k++) begin
			w16 = k[0];
			cfg({14'h0, w16, 1'b1} | 16'h0004);
			repeat (4) begin
				d = $urandom;
				q = $urandom;
				wr(ssd_pkg::OFF_DATA, {16'h0, d});
				st(1, 1'h0);
				u_lnk.select();
				chk(miso_oe, 1'h1);
				st(7, 1'h1);
				xf(q, d);
				u_lnk.deselect();
				chk(miso_oe, 1'h0);
				st(7, 1'h0);
				st(0, 1'h1);
				chk(dreq, 1'h0);
				rd(ssd_pkg::OFF_DATA);
				chk(rdat, m(q));
				st(0, 1'h0);
				st(1, 1'h1);
				rxc = crc(rxc, q);
				txc = crc(txc, d);
			end
			// accumulators are read only after deselect, never while busy
			rd(ssd_pkg::OFF_RX_CHECKSUM_ACCUMULATOR);
			chk(rdat, rxc);
			rd(ssd_pkg::OFF_TX_CHECKSUM_ACCUMULATOR);
			chk(rdat, txc);
		end
		$display("test frames done");
		wr(ssd_pkg::OFF_DATA, {16'h0, d});
		wr(ssd_pkg::OFF_DATA, {16'h0, ~d});
		u_lnk.select();
		xf(q, d);
		xf(~q, ~d);
		u_lnk.deselect();
		st(6, 1'h1);
		rd(ssd_pkg::OFF_DATA);
		chk(rdat, q);
		wr(ssd_pkg::OFF_STATUS, 32'hffbf);
		st(6, 1'h0);
		mfault <= 1'h1;
		@(posedge clk_i);
		mfault <= 1'h0;
		st(5, 1'h1);
		wr(ssd_pkg::OFF_STATUS, 32'hffdf);
		rd(ssd_pkg::OFF_STATUS);
		chk(rdat & 32'hfffb, 32'h2);
		wr(ssd_pkg::OFF_CTRL, 32'h17);
		u_lnk.select();
		xf(q, 16'h0000);
		u_lnk.deselect();
		chk(dreq, 1'h1);
		rd(ssd_pkg::OFF_DATA);
		@(posedge clk_i);
		chk(dreq, 1'h0);
		$display("test flags done");
		cfg(16'h0007);
		rd(ssd_pkg::OFF_RX_CHECKSUM_ACCUMULATOR);
		chk(rdat, 32'h0);
		rd(ssd_pkg::OFF_TX_CHECKSUM_ACCUMULATOR);
		chk(rdat, 32'h0);
		wr(ssd_pkg::OFF_DATA, {16'h0, d});
		u_lnk.select();
		wr(ssd_pkg::OFF_CTRL, 32'hf);
		xf(q, d);
		rxc = crc(rxc, q);
		txc = crc(txc, d);
		xf(~rxc, txc);
		u_lnk.deselect();
		st(4, 1'h1);
		wr(ssd_pkg::OFF_STATUS, 32'hffef);
		st(4, 1'h0);
		$display("test checksum done");
		w16 = 1'h0;
		cfg(16'h0021);
		ws <= 1'h1;
		// the pin needs its synchroniser delay before the status shows it
		repeat (6) @(posedge clk_i);
		st(2, 1'h1);
		ws <= 1'h0;
		repeat (6) @(posedge clk_i);
		st(2, 1'h0);
		u_lnk.select();
		xf(q, 16'h0000);
		u_lnk.deselect();
		st(3, 1'h1);
		wr(ssd_pkg::OFF_STATUS, 32'hfff7);
		st(3, 1'h0);
		$display("test audio done");
		cfg(16'h0001);
		for (int i = 0; i < 9; i++) begin
			d = $urandom;
			fq.push_back(d);
			if (i < 8)
				wr(ssd_pkg::OFF_DATA, {16'h0, d});
		end
		st(1, 1'h0);
		fork
			wr(ssd_pkg::OFF_DATA, {16'h0, d});
			begin
				repeat (6) @(posedge clk_i);
				chk(pready, 1'h0);
				u_lnk.select();
				for (int i = 0; i < 9; i++) begin
					q = $urandom;
					xf(q, fq[i]);
				end
				u_lnk.deselect();
			end
		join
		st(1, 1'h1);
		$display("test fifo done");
		end_sim();
	end
endmodule
